// [cisa_pkg.sv]
// shared constants, field layouts and types of the compact decoder
// assumes one core clock; all users write cisa_pkg::name
package cisa_pkg;
	localparam int HQ_DEPTH = 6;                // halfword queue slots
	localparam int ELEM_HW_NARROW = 2;          // halfwords in 32-bit element
	localparam int ELEM_HW_WIDE = 4;            // halfwords in 64-bit element
	localparam logic [2:0] ACCEPT_MAX_CNT = 3'h2; // room for a wide element
	localparam logic [31:0] HW_BYTES = 32'h2;   // bytes per halfword
	localparam int PC_HW_HI = 2;                // halfword index bits of pc
	localparam int PC_HW_LO = 1;
	// field positions inside the first halfword
	localparam int MAJ_HI = 15;
	localparam int MAJ_LO = 10;
	localparam int LEN_HI = 2;
	localparam int LEN_LO = 0;
	localparam logic [2:0] LEN16_MIN = 3'h1;   // low major bits for 16-bit
	localparam logic [2:0] LEN16_MAX = 3'h3;
	localparam int R5A_HI = 9;
	localparam int R5A_LO = 5;
	localparam int R5B_HI = 4;
	localparam int R5B_LO = 0;
	localparam int R3A_HI = 9;
	localparam int R3A_LO = 7;
	localparam int R3B_HI = 6;
	localparam int R3B_LO = 4;
	localparam int R3C_HI = 3;
	localparam int R3C_LO = 1;
	localparam int MINOR_BIT = 0;
	localparam int IMM4_HI = 4;
	localparam int IMM4_LO = 1;
	localparam int IMM9_HI = 9;
	localparam int IMM9_LO = 1;
	localparam int IMM3_HI = 3;
	localparam int IMM3_LO = 1;
	localparam int IMM6_HI = 6;
	localparam int IMM6_LO = 1;
	localparam int OFF10_HI = 9;
	localparam int OFF10_LO = 0;
	localparam int OFF5_HI = 4;
	localparam int OFF5_LO = 0;
	localparam int CMIN_HI = 5;
	localparam int CMIN_LO = 0;
	localparam int WORD_SHIFT = 2;              // stack offset scaling
	localparam int BRANCH_SHIFT = 1;            // branch offset scaling
	// major opcode values of the compact groups
	localparam logic [5:0] MAJ_POOL_A = 6'h01;
	localparam logic [5:0] MAJ_POOL_C = 6'h11;
	localparam logic [5:0] MAJ_POOL_D = 6'h13;
	localparam logic [5:0] MAJ_POOL_E = 6'h1b;
	localparam logic [5:0] MAJ_COPY = 6'h03;
	localparam logic [5:0] MAJ_LW_SP = 6'h12;
	localparam logic [5:0] MAJ_SW_SP = 6'h32;
	localparam logic [5:0] MAJ_BRANCH = 6'h33;
	localparam logic [5:0] CMIN_BREAK = 6'h28;
	localparam logic [5:0] CMIN_DBREAK = 6'h2c;
	localparam logic [4:0] REG_ZERO = 5'h00;
	localparam logic [4:0] REG_SP = 5'h1d;      // stack_pointer_reg
	// 3-bit specifier to general_register number
	localparam logic [4:0] REG3_MAP [8] = '{5'h00, 5'h11, 5'h02, 5'h03,
		5'h04, 5'h05, 5'h06, 5'h07};

	// decoded operation class
	typedef enum logic [3:0] {
		OP_OTHER16 = 4'b0000,
		OP_OTHER32 = 4'b0001,
		OP_ADDIU   = 4'b0010,
		OP_ADDU    = 4'b0011,
		OP_SUBU    = 4'b0100,
		OP_NEG     = 4'b0101,
		OP_COPY    = 4'b0110,
		OP_NOP     = 4'b0111,
		OP_LW      = 4'b1000,
		OP_SW      = 4'b1001,
		OP_BRANCH  = 4'b1010,
		OP_BREAK   = 4'b1011,
		OP_DBREAK  = 4'b1100
	} cisa_op_t;

	// one decoded instruction
	typedef struct packed {
		cisa_op_t    op;
		logic        is16;      // single-halfword instruction
		logic [4:0]  rd;        // destination
		logic [4:0]  rs;        // first source
		logic [4:0]  rt;        // second source
		logic [31:0] imm;       // scaled, extended immediate
		logic [31:0] target;    // branch target
	} cisa_dec_t;
endpackage

// [cisa_hw_order.sv]
// puts the halfwords of a fetch element into instruction order
// assumes the element sits in the low 32 bits when it is narrow
`timescale 1ns/1ps
module cisa_hw_order (
	input  wire logic [63:0]      elem,
	input  wire logic             wide,
	input  wire logic             big_endian,
	output logic [3:0][15:0]      hw_seq
);
	// first unit from the upper half in big-endian, lower half otherwise
	always_comb begin
		if (big_endian && wide) begin
			hw_seq = {elem[15:0], elem[31:16], elem[47:32], elem[63:48]};
		end else if (big_endian) begin
			hw_seq = {16'h0000, 16'h0000, elem[15:0], elem[31:16]};
		end else if (wide) begin
			hw_seq = {elem[63:48], elem[47:32], elem[31:16], elem[15:0]};
		end else begin
			hw_seq = {16'h0000, 16'h0000, elem[31:16], elem[15:0]};
		end
	end
endmodule

// [cisa_decoder.sv]
// halfword queue, instruction assembly and compact-form decode
// assumes fetch elements arrive in ascending address order
//
// Overview of operation
// - big-endian: first unit from upper half
// - little-endian: first unit from lower half
// - 32-bit halves ordered like 16-bit units
// - major-opcode halfword is first when assembling
// - 5-bit specifier is the plain register number
// - register copy has two full 5-bit fields
// - stack load/store offset shifted left two
// - branch offset shifted left one
// - no-op is copy r0 to r0
// - negate is subtract from register zero
// - same-register add: 5-bit reg, 4-bit imm
// - stack-pointer add: 9-bit imm, no reg
// - two-register add: 3-bit regs, 3-bit imm
// - add from stack pointer: 6-bit imm
// - breakpoints occupy one halfword only
// - length decided by major opcode alone
`timescale 1ns/1ps
module cisa_decoder (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             big_endian,
	input  wire logic             redirect_valid,
	input  wire logic [31:0]      redirect_pc,
	input  wire logic             fetch_valid,
	input  wire logic             fetch_wide,
	input  wire logic [63:0]      fetch_word,
	output logic                  fetch_ready,
	input  wire logic             out_ready,
	output logic                  out_valid,
	output logic [31:0]           out_instr,
	output logic [31:0]           out_pc,
	output cisa_pkg::cisa_dec_t   out_dec
);
	logic [15:0]         hq_q [cisa_pkg::HQ_DEPTH];  // halfword queue
	logic [15:0]         hq_d [cisa_pkg::HQ_DEPTH];
	logic [2:0]          cnt_q;                      // queued halfwords
	logic [2:0]          cnt_d;
	logic [1:0]          skip_q;                     // units to drop
	logic [1:0]          skip_eff;                   // skip for this element
	logic [31:0]         head_pc_q;                  // pc of queue head
	logic                ready_q;                    // registered ready
	logic [3:0][15:0]    hw_seq;                     // ordered element
	logic                accept;                     // element taken
	logic                head16;                     // head is 16-bit
	logic [2:0]          take;                       // halfwords issued
	logic [2:0]          n_acc;                      // halfwords appended
	logic [15:0]         h;                          // head halfword
	logic [5:0]          maj;                        // major opcode
	logic [31:0]         asm_instr;                  // assembled word
	cisa_pkg::cisa_dec_t dec;                        // head decode
	logic                out_valid_q;
	logic [31:0]         out_instr_q;
	logic [31:0]         out_pc_q;
	cisa_pkg::cisa_dec_t out_dec_q;

	// element halfwords in instruction order
	cisa_hw_order u_order (
		.elem       (fetch_word),
		.wide       (fetch_wide),
		.big_endian (big_endian),
		.hw_seq     (hw_seq)
	);

	assign h = hq_q[0];
	assign maj = h[cisa_pkg::MAJ_HI:cisa_pkg::MAJ_LO];
	// size from the major opcode and nothing else
	assign head16 = (maj[cisa_pkg::LEN_HI:cisa_pkg::LEN_LO] >=
		cisa_pkg::LEN16_MIN) && (maj[cisa_pkg::LEN_HI:cisa_pkg::LEN_LO] <=
		cisa_pkg::LEN16_MAX);
	assign accept = fetch_valid && ready_q && !redirect_valid;

	// issue when the whole instruction is queued and the output is free
	assign take = (out_valid_q && !out_ready) ? 3'h0 :
		(head16 && cnt_q >= 3'h1) ? 3'h1 :
		(!head16 && cnt_q >= 3'h2) ? 3'h2 : 3'h0;
	// a narrow element has only pc[1] as its alignment skip
	assign skip_eff = fetch_wide ? skip_q : {1'h0, skip_q[0]};
	assign n_acc = !accept ? 3'h0 : fetch_wide ?
		3'(cisa_pkg::ELEM_HW_WIDE) - 3'(skip_eff) :
		3'(cisa_pkg::ELEM_HW_NARROW) - 3'(skip_eff);

	// shift out issued units, append new ones behind the rest
	always_comb begin
		int k;
		int rest;
		k = 0;
		rest = int'(cnt_q) - int'(take);
		for (int i = 0; i < cisa_pkg::HQ_DEPTH; i++) begin
			hq_d[i] = 16'h0000;
			if (i < rest) begin
				hq_d[i] = hq_q[i + int'(take)];
			end else begin
				k = i - rest;
				if (k < int'(n_acc)) begin
					hq_d[i] = hw_seq[k + int'(skip_eff)];
				end
			end
		end
		cnt_d = 3'(rest) + n_acc;
	end

	// assemble: major-opcode halfword goes to the upper half of a 32-bit word, the lower half of a 16-bit one
	assign asm_instr = head16 ? {16'h0000, h} : {h, hq_q[1]};

	// decode of the frequent compact forms
	always_comb begin
		dec = '0;
		dec.is16 = head16;
		dec.op = head16 ? cisa_pkg::OP_OTHER16 : cisa_pkg::OP_OTHER32;
		case (maj)
			cisa_pkg::MAJ_POOL_D: begin
				dec.op = cisa_pkg::OP_ADDIU;
				if (!h[cisa_pkg::MINOR_BIT]) begin
					// same register as source and destination
					dec.rd = h[cisa_pkg::R5A_HI:cisa_pkg::R5A_LO];
					dec.rs = dec.rd;
					dec.imm = 32'($signed(
						h[cisa_pkg::IMM4_HI:cisa_pkg::IMM4_LO]));
				end else begin
					// implicit stack pointer both ways
					dec.rd = cisa_pkg::REG_SP;
					dec.rs = cisa_pkg::REG_SP;
					dec.imm = 32'($signed(
						h[cisa_pkg::IMM9_HI:cisa_pkg::IMM9_LO]));
				end
			end
			cisa_pkg::MAJ_POOL_E: begin
				dec.op = cisa_pkg::OP_ADDIU;
				dec.rd = cisa_pkg::REG3_MAP[h[cisa_pkg::R3A_HI:cisa_pkg::R3A_LO]];
				if (!h[cisa_pkg::MINOR_BIT]) begin
					// separate 3-bit source
					dec.rs = cisa_pkg::REG3_MAP[
						h[cisa_pkg::R3B_HI:cisa_pkg::R3B_LO]];
					dec.imm = 32'(h[cisa_pkg::IMM3_HI:cisa_pkg::IMM3_LO]);
				end else begin
					// stack pointer as implicit source
					dec.rs = cisa_pkg::REG_SP;
					dec.imm = 32'(h[cisa_pkg::IMM6_HI:cisa_pkg::IMM6_LO]);
				end
			end
			cisa_pkg::MAJ_POOL_A: begin
				dec.rd = cisa_pkg::REG3_MAP[h[cisa_pkg::R3C_HI:cisa_pkg::R3C_LO]];
				dec.rs = cisa_pkg::REG3_MAP[h[cisa_pkg::R3B_HI:cisa_pkg::R3B_LO]];
				dec.rt = cisa_pkg::REG3_MAP[h[cisa_pkg::R3A_HI:cisa_pkg::R3A_LO]];
				if (!h[cisa_pkg::MINOR_BIT]) begin
					dec.op = cisa_pkg::OP_ADDU;
				end else if (dec.rs == cisa_pkg::REG_ZERO) begin
					dec.op = cisa_pkg::OP_NEG;
				end else begin
					dec.op = cisa_pkg::OP_SUBU;
				end
			end
			cisa_pkg::MAJ_COPY: begin
				// both fields full width, taken as plain numbers
				dec.rd = h[cisa_pkg::R5A_HI:cisa_pkg::R5A_LO];
				dec.rs = h[cisa_pkg::R5B_HI:cisa_pkg::R5B_LO];
				if (dec.rd == cisa_pkg::REG_ZERO &&
					dec.rs == cisa_pkg::REG_ZERO) begin
					dec.op = cisa_pkg::OP_NOP;
				end else begin
					dec.op = cisa_pkg::OP_COPY;
				end
			end
			cisa_pkg::MAJ_LW_SP, cisa_pkg::MAJ_SW_SP: begin
				dec.op = (maj == cisa_pkg::MAJ_LW_SP) ? cisa_pkg::OP_LW :
					cisa_pkg::OP_SW;
				dec.rd = h[cisa_pkg::R5A_HI:cisa_pkg::R5A_LO];
				dec.rs = cisa_pkg::REG_SP;
				dec.imm = 32'(h[cisa_pkg::OFF5_HI:cisa_pkg::OFF5_LO])
					<< cisa_pkg::WORD_SHIFT;
			end
			cisa_pkg::MAJ_BRANCH: begin
				dec.op = cisa_pkg::OP_BRANCH;
				dec.imm = 32'($signed(h[cisa_pkg::OFF10_HI:cisa_pkg::OFF10_LO]))
					<<< cisa_pkg::BRANCH_SHIFT;
				dec.target = head_pc_q + dec.imm;
			end
			cisa_pkg::MAJ_POOL_C: begin
				if (h[cisa_pkg::CMIN_HI:cisa_pkg::CMIN_LO] ==
					cisa_pkg::CMIN_BREAK) begin
					dec.op = cisa_pkg::OP_BREAK;
				end else if (h[cisa_pkg::CMIN_HI:cisa_pkg::CMIN_LO] ==
					cisa_pkg::CMIN_DBREAK) begin
					dec.op = cisa_pkg::OP_DBREAK;
				end
			end
			default: begin
				dec.rd = cisa_pkg::REG_ZERO;
			end
		endcase
	end

	// queue storage and fill level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 3'h0;
			for (int i = 0; i < cisa_pkg::HQ_DEPTH; i++) begin
				hq_q[i] <= 16'h0000;
			end
		end else if (redirect_valid) begin
			cnt_q <= 3'h0;
		end else begin
			cnt_q <= cnt_d;
			hq_q <= hq_d;
		end
	end

	// ready only while a wide element still fits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ready_q <= 1'b1;
		end else if (redirect_valid) begin
			ready_q <= 1'b1;
		end else begin
			ready_q <= (cnt_d <= cisa_pkg::ACCEPT_MAX_CNT);
		end
	end

	// head pc and units to drop from the first element after redirect
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			head_pc_q <= 32'h0000_0000;
			skip_q <= 2'h0;
		end else if (redirect_valid) begin
			head_pc_q <= redirect_pc;
			skip_q <= redirect_pc[cisa_pkg::PC_HW_HI:cisa_pkg::PC_HW_LO];
		end else begin
			head_pc_q <= head_pc_q + 32'(take) * cisa_pkg::HW_BYTES;
			if (accept) begin
				skip_q <= 2'h0;
			end
		end
	end

	// output stage, held while downstream stalls
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_valid_q <= 1'b0;
			out_instr_q <= 32'h0000_0000;
			out_pc_q <= 32'h0000_0000;
			out_dec_q <= '0;
		end else if (redirect_valid) begin
			out_valid_q <= 1'b0;
		end else if (take != 3'h0) begin
			out_valid_q <= 1'b1;
			out_instr_q <= asm_instr;
			out_pc_q <= head_pc_q;
			out_dec_q <= dec;
		end else if (out_ready) begin
			out_valid_q <= 1'b0;
		end
	end

	assign fetch_ready = ready_q;
	assign out_valid = out_valid_q;
	assign out_instr = out_instr_q;
	assign out_pc = out_pc_q;
	assign out_dec = out_dec_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_be_first;
		accept && big_endian && !fetch_wide && cnt_q == 3'h0 &&
			skip_q == 2'h0 && !$past(redirect_valid) |=>
			hq_q[0] == $past(fetch_word[31:16]) &&
			hq_q[1] == $past(fetch_word[15:0]);
	endproperty
	a_be_first: assert property (p_be_first)
		else $error("big-endian order wrong");
	property p_le_first;
		accept && !big_endian && !fetch_wide && cnt_q == 3'h0 &&
			skip_q == 2'h0 |=> hq_q[0] == $past(fetch_word[15:0]) &&
			hq_q[1] == $past(fetch_word[31:16]);
	endproperty
	a_le_first: assert property (p_le_first)
		else $error("little-endian order wrong");
	property p_wide_order;
		accept && big_endian && fetch_wide && cnt_q == 3'h0 &&
			skip_q == 2'h0 |=> hq_q[0] == $past(fetch_word[63:48]) &&
			hq_q[3] == $past(fetch_word[15:0]);
	endproperty
	a_wide_order: assert property (p_wide_order)
		else $error("wide element order wrong");
	property p_major_first;
		take == 3'h2 && !redirect_valid |=>
			out_instr_q == {$past(hq_q[0]), $past(hq_q[1])} && !out_dec_q.is16;
	endproperty
	a_major_first: assert property (p_major_first)
		else $error("32-bit halves assembled wrong");
	property p_len16;
		take == 3'h1 && !redirect_valid |=> out_dec_q.is16 &&
			out_instr_q[31:16] == 16'h0000 && cnt_q == $past(cnt_d);
	endproperty
	a_len16: assert property (p_len16)
		else $error("16-bit issue wrong");
	property p_sp_scale;
		out_valid_q && (out_dec_q.op == cisa_pkg::OP_LW ||
			out_dec_q.op == cisa_pkg::OP_SW) |->
			out_dec_q.imm == {25'h0, out_instr_q[4:0], 2'h0} &&
			out_dec_q.rs == cisa_pkg::REG_SP;
	endproperty
	a_sp_scale: assert property (p_sp_scale)
		else $error("stack offset not scaled by four");
	property p_branch;
		out_valid_q && out_dec_q.op == cisa_pkg::OP_BRANCH |->
			out_dec_q.target == out_pc_q +
			{{21{out_instr_q[9]}}, out_instr_q[9:0], 1'b0};
	endproperty
	a_branch: assert property (p_branch)
		else $error("branch target wrong");
	property p_nop;
		out_valid_q && out_instr_q[15:10] == cisa_pkg::MAJ_COPY &&
			out_instr_q[9:0] == 10'h000 |-> out_dec_q.op == cisa_pkg::OP_NOP;
	endproperty
	a_nop: assert property (p_nop)
		else $error("copy r0 to r0 not a no-op");
	property p_neg;
		out_valid_q && out_dec_q.op == cisa_pkg::OP_NEG |->
			out_dec_q.rs == cisa_pkg::REG_ZERO && out_instr_q[0];
	endproperty
	a_neg: assert property (p_neg)
		else $error("negate without register zero");
	property p_stall;
		out_valid_q && !out_ready && !redirect_valid |=>
			out_valid_q && $stable(out_instr_q);
	endproperty
	a_stall: assert property (p_stall)
		else $error("output lost during stall");
endmodule

// [cisa_fetch_model.sv]
// fetch unit and instruction memory that feed the compact decoder
// assumes the bench fills mem and pulses start with each redirect
`timescale 1ns/1ps
module cisa_fetch_model (
	input  wire logic        clk,
	input  wire logic        start,       // redirect seen by the decoder
	input  wire logic [31:0] start_pc,    // address of first instruction
	input  wire logic [5:0]  n_elem,      // elements to offer this run
	input  wire logic        big_endian,
	input  wire logic        wide,
	input  wire logic        fetch_ready,
	output logic             fetch_valid,
	output logic             fetch_wide,
	output logic [63:0]      fetch_word
);
	logic [15:0] mem [64];       // halfwords in address order
	int          elem = 0;       // next element to offer
	int          lim  = 0;       // end of this run
	logic        acc  = 1'b0;    // last offer taken at the rising edge

	assign fetch_wide = wide;

	// idle and quiet at time zero
	initial begin
		fetch_valid = 1'b0;
		fetch_word  = 64'h0;
	end

	// pointer restarts at the redirect and walks upward
	always @(posedge clk) begin
		acc <= fetch_valid && fetch_ready && !start;
		if (start) begin
			elem <= int'(start_pc >> (wide ? 3 : 2));
			lim  <= int'(n_elem);
		end else if (fetch_valid && fetch_ready) begin
			elem <= elem + 1;
		end
	end

	// an offer is held until taken; stalls come at random
	always @(negedge clk) begin
		int          n;
		logic [63:0] w;
		n = wide ? 4 : 2;
		w = {$urandom, $urandom}; // junk where no unit lands
		if (!fetch_valid || acc) begin
			if (elem < lim)
				for (int k = 0; k < n; k++)
					w[16 * (big_endian ? n - 1 - k : k) +: 16] =
						mem[elem * n + k];
			fetch_valid <= elem < lim && $urandom_range(3) != 0;
			fetch_word  <= w;
		end
	end
endmodule

// [cisa_decoder_test.sv]
// self-checking bench of the compact decoder against a fetch model
// assumes the package, the decoder and the fetch model come first
`timescale 1ns/1ps
module cisa_decoder_test;
	localparam int TIMEOUT = 20000;          // cycles before giving up
	logic                clk = 1'b0;
	logic                rst = 1'b1;
	logic                big_endian = 1'b0;
	logic                wide = 1'b0;
	logic                redirect_valid = 1'b0;
	logic [31:0]         redirect_pc = 32'h0;
	logic [5:0]          n_elem = 6'h0;
	logic                out_ready = 1'b0;
	logic                fetch_valid;
	logic                fetch_wide;
	logic                fetch_ready;
	logic [63:0]         fetch_word;
	logic                out_valid;
	logic [31:0]         out_instr;
	logic [31:0]         out_pc;
	cisa_pkg::cisa_dec_t out_dec;
	int                  err_count = 0;
	int                  comparisons = 0;
	int                  cycles = 0;
	logic [64:0]         exp_q [$];      // notes of {is16, pc, instr}
	logic [5:0]          maj_tab [12] = '{cisa_pkg::MAJ_POOL_A,
		cisa_pkg::MAJ_POOL_C, cisa_pkg::MAJ_POOL_D, cisa_pkg::MAJ_POOL_E,
		cisa_pkg::MAJ_COPY, cisa_pkg::MAJ_LW_SP, cisa_pkg::MAJ_SW_SP,
		cisa_pkg::MAJ_BRANCH, 6'h00, 6'h04, 6'h07, 6'h2c};

	always #50 clk = ~clk;

	cisa_decoder cisa_decoder_inst (
		.clk(clk), .rst(rst), .big_endian(big_endian),
		.redirect_valid(redirect_valid), .redirect_pc(redirect_pc),
		.fetch_valid(fetch_valid), .fetch_wide(fetch_wide),
		.fetch_word(fetch_word), .fetch_ready(fetch_ready),
		.out_ready(out_ready), .out_valid(out_valid),
		.out_instr(out_instr), .out_pc(out_pc), .out_dec(out_dec)
	);

	cisa_fetch_model cisa_fetch_model_inst (
		.clk(clk), .start(redirect_valid), .start_pc(redirect_pc),
		.n_elem(n_elem), .big_endian(big_endian), .wide(wide),
		.fetch_ready(fetch_ready), .fetch_valid(fetch_valid),
		.fetch_wide(fetch_wide), .fetch_word(fetch_word)
	);

	// counts every compare, reports and counts each mismatch
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// single halfword when the low major bits lie in 1..3
	function automatic logic f16(logic [15:0] h);
		return h[12:10] inside {[3'h1:3'h3]};
	endfunction

	// compares one accepted instruction with its note
	task automatic check_out(logic [64:0] e);
		logic [15:0] h;
		logic        sp;
		h = e[15:0];
		sp = h[cisa_pkg::MINOR_BIT]; // stack forms carry minor 1
		check("pc", out_pc, e[63:32]);
		check("instr", out_instr, e[31:0]);
		check("is16", 32'(out_dec.is16), 32'(e[64]));
		if (e[64])
			case (h[15:10])
			cisa_pkg::MAJ_LW_SP, cisa_pkg::MAJ_SW_SP:
				check("imm", out_dec.imm, {25'h0, h[4:0], 2'h0});
			cisa_pkg::MAJ_BRANCH:
				check("target", out_dec.target,
					e[63:32] + {{21{h[9]}}, h[9:0], 1'h0});
			cisa_pkg::MAJ_COPY: begin
				check("op", 32'(out_dec.op), 32'(h[9:0] == 10'h0 ?
					cisa_pkg::OP_NOP : cisa_pkg::OP_COPY));
				check("regs", 32'({out_dec.rd, out_dec.rs}),
					32'(h[9:0]));
			end
			cisa_pkg::MAJ_POOL_D: begin
				check("rd", 32'({out_dec.rd, out_dec.rs}),
					32'({2{(sp ? cisa_pkg::REG_SP : h[9:5])}}));
				check("imm", out_dec.imm, sp ? {{23{h[9]}}, h[9:1]}
					: {{28{h[4]}}, h[4:1]});
			end
			cisa_pkg::MAJ_POOL_E: begin
				check("rd", 32'(out_dec.rd),
					32'(cisa_pkg::REG3_MAP[h[9:7]]));
				check("imm", out_dec.imm,
					sp ? 32'(h[6:1]) : 32'(h[3:1]));
				check("rs", 32'(out_dec.rs),
					32'(sp ? cisa_pkg::REG_SP : cisa_pkg::REG3_MAP[h[6:4]]));
			end
			cisa_pkg::MAJ_POOL_A: begin
				check("op", 32'(out_dec.op),
					32'(!h[0] ? cisa_pkg::OP_ADDU :
					cisa_pkg::REG3_MAP[h[6:4]] == cisa_pkg::REG_ZERO ?
					cisa_pkg::OP_NEG : cisa_pkg::OP_SUBU));
				check("regs",
					32'({out_dec.rd, out_dec.rs, out_dec.rt}),
					32'({cisa_pkg::REG3_MAP[h[3:1]], cisa_pkg::REG3_MAP[h[6:4]],
					cisa_pkg::REG3_MAP[h[9:7]]}));
			end
			cisa_pkg::MAJ_POOL_C:
				check("op", 32'(out_dec.op),
					32'(h[5:0] == cisa_pkg::CMIN_BREAK ?
					cisa_pkg::OP_BREAK : cisa_pkg::OP_DBREAK));
			default: ;
			endcase
	endtask

	// random program; ends stay single so every run can close
	task automatic build(int n);
		logic [15:0] h;
		int          i;
		i = 0;
		while (i < n) begin
			h = 16'($urandom);
			h[15:10] = maj_tab[$urandom_range(11)];
			if (h[15:10] == cisa_pkg::MAJ_POOL_C)
				h[5:0] = $urandom_range(1) ? cisa_pkg::CMIN_BREAK
					: cisa_pkg::CMIN_DBREAK;
			if (!f16(h) && (i == 0 || i == n - 1))
				h = {cisa_pkg::MAJ_COPY, 10'h0}; // no-op filler
			cisa_fetch_model_inst.mem[i] = h;
			if (!f16(h))
				cisa_fetch_model_inst.mem[i + 1] = 16'($urandom);
			i += f16(h) ? 1 : 2;
		end
		// keeps the same-register add apart from the stack form
		for (int k = 0; k < n; k++)
			if (cisa_fetch_model_inst.mem[k][9:5] == cisa_pkg::REG_SP)
				cisa_fetch_model_inst.mem[k][9] = 1'b0;
	endtask

	// one run: notes the program from halfword s, then redirects there
	task automatic run(logic be, logic wd, int s);
		int          n;
		int          i;
		logic [15:0] h;
		@(negedge clk);
		n = wd ? 48 : 40;
		big_endian = be;
		wide = wd;
		n_elem = wd ? 6'h0c : 6'h14;
		build(n);
		i = s;
		while (i < n) begin
			h = cisa_fetch_model_inst.mem[i];
			if (f16(h))
				exp_q.push_back({1'h1, 32'(i * 2), 16'h0, h});
			else if (i + 1 < n)
				exp_q.push_back({1'h0, 32'(i * 2), h,
					cisa_fetch_model_inst.mem[i + 1]});
			i += f16(h) ? 1 : 2;
		end
		redirect_pc = 32'(s * 2);
		redirect_valid = 1'b1;
		@(negedge clk);
		redirect_valid = 1'b0;
		while (exp_q.size() != 0)
			@(negedge clk);
		repeat (4) @(negedge clk); // any stray output shows here
	endtask

	task automatic print_verdict();
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// takes the oldest note whenever an instruction is accepted
	always @(posedge clk) begin
		if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
			if (exp_q.size() == 0)
				check("extra", 32'h1, 32'h0);
			else
				check_out(exp_q.pop_front());
		end
	end

	// downstream stalls at random
	always @(negedge clk)
		out_ready <= $urandom_range(3) != 0;

	// cuts a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == TIMEOUT) begin
			err_count++;
			print_verdict();
		end
	end

	// every endian and width, then redirects into mid-element
	initial begin
		void'($urandom(32'h59e6));
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		for (int t = 0; t < 4; t++)
			run(t[0], t[1], 0);
		run(1'b0, 1'b0, 1);
		run(1'b1, 1'b1, 1);
		run(1'b0, 1'b1, 2);
		print_verdict();
	end
endmodule
